// ---- logic/cpu_bus_control.sv ----
// machine cycle sequencer, hold handshake and interrupt gate at the cpu pins
//
// Operation
// - data bus driven only for the status byte and while outputting
// - reset clears program counter, disables interrupts
// - hold request floats address and data buses
// - hold acknowledge high while in hold
// - no interrupt accepted while in hold
// - irq sampled when halted or instruction end
// - accept unless enable low, hold or reset pin high
// - enable opcode sets flag, mask clears it
// - accept and reset pin clear enable flag
// - input strobe high in input mode only
// - address on bus from first state
// - cycle start strobe carries status byte
// - wait output high until ready
// - status byte bit layout on data bus
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "cpu_bus_params.svh"

module cpu_bus_control #(
  parameter int ADDR_W    = `ADDR_WIDTH,       // address bus width
  parameter int RESET_MIN = `RESET_MIN_CYCLES  // cycles the reset pin must stand
) (
  input  wire logic                   i_clk,         // 10 MHz clock
  input  wire logic                   i_resetn,      // async reset, active low
  input  wire logic [`REG_ADDR_W-1:0] i_reg_addr,    // register address
  input  wire logic [`REG_DATA_W-1:0] i_reg_wdata,   // register write data
  input  wire logic                   i_reg_write,   // write strobe
  input  wire logic                   i_reg_read,    // read strobe
  output logic      [`REG_DATA_W-1:0] o_reg_rdata,   // read data, cycle after strobe
  input  wire logic                   i_cpu_reset,   // reset pin, active high
  input  wire logic                   i_hold_req,    // bus release request pin
  input  wire logic                   i_irq,         // interrupt request pin
  input  wire logic                   i_ready,       // ready pin
  input  wire logic [`DATA_WIDTH-1:0] i_data,        // data bus, pin level
  output logic      [`DATA_WIDTH-1:0] o_data,        // data bus, driven value
  output logic                        o_data_oe,     // data bus enable
  output logic      [ADDR_W-1:0]      o_addr,        // address bus value
  output logic                        o_addr_oe,     // address bus enable
  output logic                        o_sync,        // cycle start strobe
  output logic                        o_data_bus_input_strobe,        // data bus input strobe
  output logic                        o_write_n,     // write strobe, active low
  output logic                        o_wait,        // wait state
  output logic                        o_hold_acknowledge,        // hold acknowledge
  output logic                        o_irq_enable,  // irq enable flag
  output logic                        o_irq_accept   // irq accepted, pulse
);

  generate
    if (ADDR_W < 1 || ADDR_W > `REG_DATA_W)
    begin : g_chk
      $error("cpu_bus_control: ADDR_W must be 1 to 16");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic is_read(input logic [`DATA_WIDTH-1:0] sb);
    is_read = sb[`SB_READ_BIT];
  endfunction
  function automatic logic in_xfer(input cpu_bus_pkg::bus_state_t s);
    in_xfer = (s == cpu_bus_pkg::ST_T2) || (s == cpu_bus_pkg::ST_WAIT) || (s == cpu_bus_pkg::ST_T3);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and reset qualification
  wire [`DATA_WIDTH+3:0] pins_lvl;
  wire                   rst_lvl;
  wire                   hold_lvl;
  wire                   irq_lvl;
  wire                   ready_lvl;
  wire [`DATA_WIDTH-1:0] data_lvl;
  wire                   rst_act;

  pin_sync #(
    .WIDTH (`DATA_WIDTH + 4)
  ) u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_pin    ({i_data, i_ready, i_irq, i_hold_req, i_cpu_reset}),
    .o_level  (pins_lvl)
  );

  assign rst_lvl   = pins_lvl[0];
  assign hold_lvl  = pins_lvl[1];
  assign irq_lvl   = pins_lvl[2];
  assign ready_lvl = pins_lvl[3];
  assign data_lvl  = pins_lvl[`DATA_WIDTH+3:4];

  // short glitches on the reset pin do not reset the sequencer
  reset_qualifier #(
    .MIN_CYCLES (RESET_MIN)
  ) u_rstq (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_level  (rst_lvl),
    .o_active (rst_act)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state
  cpu_bus_pkg::bus_state_t state_reg;
  cpu_bus_pkg::bus_state_t state_next;
  logic [ADDR_W-1:0]      pc_reg;
  logic [ADDR_W-1:0]      addr_reg;
  logic [`DATA_WIDTH-1:0] wdata_reg;
  logic [`DATA_WIDTH-1:0] rdata_reg;
  logic [`DATA_WIDTH-1:0] sbyte_reg;
  logic                   pend_reg;
  logic                   irq_enable_flag_reg;
  logic                   halted_reg;
  logic                   irq_taken_reg;
  logic                   accept_reg;
  logic [`REG_DATA_W-1:0] reg_rdata_reg;
  logic [`DATA_WIDTH-1:0] dout_reg;
  logic                   dout_oe_reg;
  logic [ADDR_W-1:0]      aout_reg;
  logic                   aout_oe_reg;
  logic                   sync_reg;
  logic                   data_bus_input_strobe_reg;
  logic                   write_n_reg;
  logic                   wait_reg;
  logic                   hold_acknowledge_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register port decode
  wire wr_cycle = i_reg_write && (i_reg_addr == `REG_CYCLE);
  wire wr_addr  = i_reg_write && (i_reg_addr == `REG_ADDR);
  wire wr_wdata = i_reg_write && (i_reg_addr == `REG_WDATA);
  wire wr_ctrl  = i_reg_write && (i_reg_addr == `REG_CTRL);
  wire cmd_ei   = wr_ctrl && i_reg_wdata[`CTRL_EI_BIT];
  wire cmd_di   = wr_ctrl && i_reg_wdata[`CTRL_DI_BIT];
  wire cmd_iend = wr_ctrl && i_reg_wdata[`CTRL_IEND_BIT];
  wire cmd_halt = wr_ctrl && i_reg_wdata[`CTRL_HALT_BIT];
  wire cmd_clr  = wr_ctrl && i_reg_wdata[`CTRL_CLR_IRQ_BIT];
  wire busy     = pend_reg || (state_reg != cpu_bus_pkg::ST_IDLE && state_reg != cpu_bus_pkg::ST_HOLD);
  wire [`REG_DATA_W-1:0] status_word = `REG_DATA_W'({wait_reg, irq_taken_reg, halted_reg, hold_acknowledge_reg, irq_enable_flag_reg, busy});
  logic [`REG_DATA_W-1:0] rd_mux;
  // read mux, unmapped offsets read as zero
  always_comb
  begin
    if (i_reg_addr == `REG_CYCLE)
      rd_mux = `REG_DATA_W'(sbyte_reg);
    else if (i_reg_addr == `REG_ADDR)
      rd_mux = `REG_DATA_W'(addr_reg);
    else if (i_reg_addr == `REG_WDATA)
      rd_mux = `REG_DATA_W'(wdata_reg);
    else if (i_reg_addr == `REG_RDATA)
      rd_mux = `REG_DATA_W'(rdata_reg);
    else if (i_reg_addr == `REG_STATUS)
      rd_mux = status_word;
    else if (i_reg_addr == `REG_PC)
      rd_mux = `REG_DATA_W'(pc_reg);
    else
      rd_mux = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt sampling: only at instruction end or while halted, never in hold
  wire sample_pt = cmd_iend || halted_reg;
  wire accept    = sample_pt && irq_lvl && irq_enable_flag_reg && !rst_lvl
                   && state_reg != cpu_bus_pkg::ST_HOLD && !hold_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // machine cycle sequencer; hold is taken only between cycles
  wire cyc_read  = is_read(sbyte_reg);
  wire cyc_fetch = sbyte_reg[`SB_FETCH_BIT];
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      cpu_bus_pkg::ST_IDLE:
        if (hold_lvl)
          state_next = cpu_bus_pkg::ST_HOLD;
        else if (pend_reg)
          state_next = cpu_bus_pkg::ST_T1;
      cpu_bus_pkg::ST_HOLD:
        if (!hold_lvl)
          state_next = cpu_bus_pkg::ST_IDLE;
      cpu_bus_pkg::ST_T1:
        state_next = cpu_bus_pkg::ST_T2;
      cpu_bus_pkg::ST_T2:
        state_next = ready_lvl ? cpu_bus_pkg::ST_T3 : cpu_bus_pkg::ST_WAIT;
      cpu_bus_pkg::ST_WAIT:
        if (ready_lvl)
          state_next = cpu_bus_pkg::ST_T3;
      cpu_bus_pkg::ST_T3:
        state_next = cpu_bus_pkg::ST_IDLE;
      default:
        state_next = cpu_bus_pkg::ST_IDLE;
    endcase
    if (rst_act)
      state_next = cpu_bus_pkg::ST_IDLE;
  end
  // pin outputs follow the next state so they change with it
  wire                   nx_xfer  = in_xfer(state_next);
  wire                   nx_t1    = (state_next == cpu_bus_pkg::ST_T1);
  wire                   nx_hold  = (state_next == cpu_bus_pkg::ST_HOLD);
  wire [ADDR_W-1:0]      cyc_addr = cyc_fetch ? pc_reg : addr_reg;
  wire                   enter_t1 = nx_t1 && (state_reg != cpu_bus_pkg::ST_T1);
  wire                   end_cyc  = (state_reg == cpu_bus_pkg::ST_T3);
  wire [`DATA_WIDTH-1:0] dout_nx  = nx_t1 ? sbyte_reg : wdata_reg;
  wire                   doe_nx   = nx_t1 || (nx_xfer && !cyc_read);
  wire                   data_bus_input_strobe_nx  = nx_xfer && cyc_read;

  ////////////////////////////////////////////////////////////////////////////
  // pin registers
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg   <= cpu_bus_pkg::ST_IDLE;
      dout_reg    <= '0;
      dout_oe_reg <= 1'b0;
      aout_reg    <= '0;
      aout_oe_reg <= 1'b0;
      sync_reg    <= 1'b0;
      data_bus_input_strobe_reg    <= 1'b0;
      write_n_reg <= 1'b1;
      wait_reg    <= 1'b0;
      hold_acknowledge_reg    <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      dout_reg    <= dout_nx;
      dout_oe_reg <= doe_nx && !nx_hold;
      aout_reg    <= enter_t1 ? cyc_addr : aout_reg;
      aout_oe_reg <= !nx_hold;
      sync_reg    <= nx_t1;
      data_bus_input_strobe_reg    <= data_bus_input_strobe_nx;
      write_n_reg <= !(state_next == cpu_bus_pkg::ST_T3 && !cyc_read);
      wait_reg    <= (state_next == cpu_bus_pkg::ST_WAIT);
      hold_acknowledge_reg    <= nx_hold;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle, program counter and interrupt state
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pc_reg        <= ADDR_W'(`PC_RESET);
      addr_reg      <= '0;
      wdata_reg     <= '0;
      rdata_reg     <= '0;
      sbyte_reg     <= '0;
      pend_reg      <= 1'b0;
      irq_enable_flag_reg      <= 1'b0;
      halted_reg    <= 1'b0;
      irq_taken_reg <= 1'b0;
      accept_reg    <= 1'b0;
      reg_rdata_reg <= '0;
    end
    else
    begin
      addr_reg      <= wr_addr ? i_reg_addr == `REG_ADDR ? ADDR_W'(i_reg_wdata) : addr_reg : addr_reg;
      wdata_reg     <= wr_wdata ? i_reg_wdata[`DATA_WIDTH-1:0] : wdata_reg;
      reg_rdata_reg <= i_reg_read ? rd_mux : '0;
      accept_reg    <= accept;
      // a new cycle request while busy is ignored
      if (wr_cycle && !busy)
      begin
        sbyte_reg <= i_reg_wdata[`DATA_WIDTH-1:0];
        pend_reg  <= 1'b1;
      end
      else if (rst_act || end_cyc)
        pend_reg  <= 1'b0;
      if (end_cyc && cyc_read)
        rdata_reg <= data_lvl;
      // qualified reset restarts fetching at location zero
      if (rst_act)
        pc_reg <= ADDR_W'(`PC_RESET);
      else if (end_cyc && cyc_fetch)
        pc_reg <= ADDR_W'(pc_reg + 1'b1);
      // a reset pin high that passes the synchroniser (rst_lvl) masks interrupts at once, without qualification
      if (rst_lvl || accept)
        irq_enable_flag_reg <= 1'b0;
      else if (cmd_di)
        irq_enable_flag_reg <= 1'b0;
      else if (cmd_ei)
        irq_enable_flag_reg <= 1'b1;
      if (rst_act || accept)
        halted_reg <= 1'b0;
      else if (cmd_halt)
        halted_reg <= 1'b1;
      // set beats clear in the same cycle
      if (accept)
        irq_taken_reg <= 1'b1;
      else if (cmd_clr)
        irq_taken_reg <= 1'b0;
    end
  end

  assign o_reg_rdata  = reg_rdata_reg;
  assign o_data       = dout_reg;
  assign o_data_oe    = dout_oe_reg;
  assign o_addr       = aout_reg;
  assign o_addr_oe    = aout_oe_reg;
  assign o_sync       = sync_reg;
  assign o_data_bus_input_strobe       = data_bus_input_strobe_reg;
  assign o_write_n    = write_n_reg;
  assign o_wait       = wait_reg;
  assign o_hold_acknowledge       = hold_acknowledge_reg;
  assign o_irq_enable = irq_enable_flag_reg;
  assign o_irq_accept = accept_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  hold_float_a: assert property (state_reg == cpu_bus_pkg::ST_HOLD |-> !o_addr_oe && !o_data_oe)
    else $error("buses driven during hold");
  hold_acknowledge_state_a: assert property (o_hold_acknowledge == (state_reg == cpu_bus_pkg::ST_HOLD))
    else $error("hold acknowledge out of step with hold state");
  no_irq_hold_a: assert property (state_reg == cpu_bus_pkg::ST_HOLD |=> !o_irq_accept)
    else $error("interrupt accepted in hold");
  irq_cause_a: assert property (o_irq_accept |-> $past(sample_pt) && $past(irq_lvl) && $past(irq_enable_flag_reg))
    else $error("interrupt accepted without cause");
  accept_clr_a: assert property (o_irq_accept |-> !o_irq_enable)
    else $error("enable flag survived accept");
  reset_pc_a: assert property ($rose(rst_act) |=> pc_reg == '0 && !o_irq_enable ##1 pc_reg == '0)
    else $error("reset did not clear state");
  ei_sets_a: assert property (cmd_ei && !cmd_di && !accept && !rst_lvl |=> o_irq_enable)
    else $error("enable opcode did not set flag");
  data_bus_input_strobe_dir_a: assert property (o_data_bus_input_strobe |-> !o_data_oe)
    else $error("driving data bus in input mode");
  sync_status_a: assert property (o_sync |-> o_data_oe && o_addr_oe && o_data == sbyte_reg ##1 !o_sync)
    else $error("cycle start without status byte");
  wait_ready_a: assert property (o_wait && ready_lvl && !rst_act |=> !o_wait && o_write_n == cyc_read)
    else $error("wait not ended by ready");

endmodule // cpu_bus_control

// ---- logic/cpu_bus_params.svh ----
// offsets, field positions, reset values and counts for the bus control block
`ifndef CPU_BUS_PARAMS_SVH
`define CPU_BUS_PARAMS_SVH

// register port geometry
`define REG_ADDR_W        8
`define REG_DATA_W        16

// register offsets
`define REG_CYCLE         8'h00
`define REG_ADDR          8'h04
`define REG_WDATA         8'h08
`define REG_RDATA         8'h0c
`define REG_CTRL          8'h10
`define REG_STATUS        8'h14
`define REG_PC            8'h18

// control register bits, write one to act
`define CTRL_EI_BIT       0
`define CTRL_DI_BIT       1
`define CTRL_IEND_BIT     2
`define CTRL_HALT_BIT     3
`define CTRL_CLR_IRQ_BIT  4

// status register bits
`define STAT_BUSY_BIT     0
`define STAT_IRQ_ENABLE_FLAG_BIT     1
`define STAT_HOLD_BIT     2
`define STAT_HALT_BIT     3
`define STAT_IRQ_BIT      4
`define STAT_WAIT_BIT     5

// machine cycle status byte positions on the data bus
`define SB_IRQ_ACK_BIT    0
`define SB_READ_BIT       1
`define SB_SP_BIT         2
`define SB_HALT_ACK_BIT   3
`define SB_OUT_BIT        4
`define SB_FETCH_BIT      5
`define SB_PORT_RD_BIT    6
`define SB_MEM_RD_BIT     7

// widths, reset values and counts
`define ADDR_WIDTH        16
`define DATA_WIDTH        8
`define PC_RESET          16'h0000
`define RESET_MIN_CYCLES  3

`endif

// ---- logic/cpu_bus_pkg.sv ----
// types shared by the bus control block
package cpu_bus_pkg;

  // machine cycle sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_T1,
    ST_T2,
    ST_WAIT,
    ST_T3,
    ST_HOLD
  } bus_state_t;

endpackage

// ---- logic/pin_sync.sv ----
// three-stage pin synchroniser, a change counts once stages two and three agree
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,    // system clock
  input  wire logic             i_resetn, // async reset, active low
  input  wire logic [WIDTH-1:0] i_pin,    // raw pin levels
  output logic      [WIDTH-1:0] o_level   // filtered levels
);

  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("pin_sync: WIDTH must be at least one");
    end
  endgenerate

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] level_reg;
  wire  [WIDTH-1:0] level_next;
  wire  [WIDTH-1:0] differ;

  ////////////////////////////////////////////////////////////////////////////
  // take the new level only where stages agree, hold it elsewhere
  assign differ     = s2_reg ^ s3_reg;
  assign level_next = (s2_reg & ~differ) | (level_reg & differ);
  assign o_level    = level_reg;

  // s1 feeds s2 only, nothing else looks at it
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      level_reg <= '0;
    end
    else
    begin
      s1_reg    <= i_pin;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

endmodule // pin_sync

// ---- logic/reset_qualifier.sv ----
// qualifies the cpu reset pin: it must stay high a minimum number of cycles
`timescale 1ns/1ps

module reset_qualifier #(
  parameter int MIN_CYCLES = 3
) (
  input  wire logic i_clk,    // system clock
  input  wire logic i_resetn, // async reset, active low
  input  wire logic i_level,  // synchronised reset pin level
  output logic      o_active  // reset qualified, level
);

  generate
    if (MIN_CYCLES < 1)
    begin : g_chk
      $error("reset_qualifier: MIN_CYCLES must be at least one");
    end
  endgenerate

  localparam int CW = $clog2(MIN_CYCLES + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(MIN_CYCLES);

  logic [CW-1:0] cnt_reg;
  logic          active_reg;
  wire  [CW-1:0] cnt_next;

  ////////////////////////////////////////////////////////////////////////////
  // count saturates so a long reset never wraps back to inactive
  assign cnt_next = !i_level ? '0 : (cnt_reg == CNT_MAX) ? cnt_reg : CW'(cnt_reg + 1'b1);
  assign o_active = active_reg;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_reg    <= '0;
      active_reg <= 1'b0;
    end
    else
    begin
      cnt_reg    <= cnt_next;
      active_reg <= (cnt_next == CNT_MAX);
    end
  end

endmodule // reset_qualifier

// ---- testbench/bus_partner.sv ----
// far side model: memory with adjustable ready and a data bus released between reads
`timescale 1ns/1ps

module bus_partner (
  input  wire logic        i_clk,   // system clock
  input  wire logic [15:0] i_addr,  // address bus from the cpu
  input  wire logic        i_data_bus_input_strobe,  // cpu is reading
  input  wire logic        i_slow,  // stretch ready to force waits
  output logic      [7:0]  o_data,  // value offered on the data bus
  output logic             o_ready  // transfer complete
);
  logic [3:0] hold_cnt = 4'h0;  // cycles the current read has waited
  logic [7:0] last     = 8'h00; // previous offer, inverted while released

  ////////////////////////////////////////////////////////////////////////////
  // read timing; saturating so a long stall cannot wrap back to not ready
  always @(posedge i_clk)
  begin
    hold_cnt <= i_data_bus_input_strobe ? ((hold_cnt == 4'hf) ? hold_cnt : hold_cnt + 4'h1) : 4'h0;
    last     <= o_data;
  end

  // ready stays low long enough to survive the pin synchroniser
  assign o_ready = !i_slow || (hold_cnt >= 4'h8);
  // memory byte is address xor 5a, so location zero holds 5a, not a halt
  assign o_data  = i_data_bus_input_strobe ? (i_addr[7:0] ^ 8'h5a) : ~last;
endmodule // bus_partner

// ---- testbench/testbench.sv ----
// self-checking bench for the cpu bus control block
`timescale 1ns/1ps
`include "cpu_bus_params.svh"

module testbench;
  logic        i_clk, i_resetn, i_reg_write, i_reg_read, i_cpu_reset, i_hold_req, i_irq, slow;
  logic [7:0]  i_reg_addr, o_data, mem_data, wbyte;
  logic [15:0] i_reg_wdata, o_reg_rdata, o_addr, addr;
  logic        o_data_oe, o_addr_oe, o_sync, o_data_bus_input_strobe, o_write_n, o_wait, o_hold_acknowledge;
  logic        o_irq_enable, o_irq_accept, ready, rd_seen;
  wire  [7:0]  bus_level = o_data_oe ? o_data : mem_data; // resolved data wire
  logic [15:0] exp_q[$];
  int          n_errors, compares, n_acc, seed, k;

  cpu_bus_control dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write), .i_reg_read(i_reg_read),
    .o_reg_rdata(o_reg_rdata), .i_cpu_reset(i_cpu_reset), .i_hold_req(i_hold_req), .i_irq(i_irq),
    .i_ready(ready), .i_data(bus_level), .o_data(o_data), .o_data_oe(o_data_oe), .o_addr(o_addr),
    .o_addr_oe(o_addr_oe), .o_sync(o_sync), .o_data_bus_input_strobe(o_data_bus_input_strobe), .o_write_n(o_write_n),
    .o_wait(o_wait), .o_hold_acknowledge(o_hold_acknowledge), .o_irq_enable(o_irq_enable), .o_irq_accept(o_irq_accept));

  bus_partner partner_u (.i_clk(i_clk), .i_addr(o_addr), .i_data_bus_input_strobe(o_data_bus_input_strobe), .i_slow(slow),
    .o_data(mem_data), .o_ready(ready));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // bounded wait for a level, sampled at the falling edge where outputs are settled
  task automatic wait_lvl(ref logic s, input logic lvl, input int bound);
    for (int i = 0; i < bound && s !== lvl; i++)
      @(negedge i_clk);
    if (s !== lvl)
    begin
      n_errors++;
      final_report();
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_write <= 1'b1;
    @(posedge i_clk);
    i_reg_write <= 1'b0;
  endtask

  // read notes its expectation; the watcher below compares when data stands
  task automatic reg_read(input logic [7:0] a, input logic [15:0] exp);
    exp_q.push_back(exp);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_read <= 1'b1;
    @(posedge i_clk);
    i_reg_read <= 1'b0;
  endtask

  task automatic pins(input logic rst, input logic hold, input logic irq);
    @(posedge i_clk);
    i_cpu_reset <= rst;
    i_hold_req  <= hold;
    i_irq       <= irq;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // read data watcher and accept counter
  always @(posedge i_clk)
  begin
    rd_seen <= i_reg_read;
    if (o_irq_accept === 1'b1)
      n_acc <= n_acc + 1;
  end

  always @(negedge i_clk)
    if (rd_seen === 1'b1 && exp_q.size() > 0)
      check("rdata", o_reg_rdata, exp_q.pop_front());

  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // counters start at zero as ints; rd_seen and n_acc belong to the watcher alone
    {i_resetn, i_reg_write, i_reg_read, i_cpu_reset, i_hold_req, i_irq, slow, i_reg_addr, i_reg_wdata} = '0;
    seed = 32'hd71110e4;
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    reg_read(`REG_PC, 16'h0000);
    reg_read(8'h1c, 16'h0000);
    check("enable", o_irq_enable, 1'b0);
    // slow read fetch at location zero
    slow <= 1'b1;
    reg_write(`REG_CYCLE, 16'h00a2);
    wait_lvl(o_sync, 1'b1, 10);
    check("status", o_data, 8'ha2);
    check("addr", o_addr, 16'h0000);
    check("addr oe", o_addr_oe, 1'b1);
    wait_lvl(o_data_bus_input_strobe, 1'b1, 4);
    check("data oe", o_data_oe, 1'b0);
    wait_lvl(o_wait, 1'b1, 10);
    wait_lvl(o_wait, 1'b0, 30);
    wait_lvl(o_data_bus_input_strobe, 1'b0, 8);
    reg_read(`REG_RDATA, 16'h005a);
    reg_read(`REG_PC, 16'h0001);
    // prompt write cycle to a random address
    slow <= 1'b0;
    addr  = 16'($random(seed));
    wbyte = 8'($random(seed));
    reg_write(`REG_ADDR, addr);
    reg_write(`REG_WDATA, {8'h00, wbyte});
    reg_write(`REG_CYCLE, 16'h0010);
    wait_lvl(o_sync, 1'b1, 10);
    check("addr", o_addr, addr);
    check("status", o_data, 8'h10);
    wait_lvl(o_write_n, 1'b0, 10);
    check("wdata", o_data, wbyte);
    check("data_bus_input_strobe", o_data_bus_input_strobe, 1'b0);
    check("data oe", o_data_oe, 1'b1);
    wait_lvl(o_write_n, 1'b1, 4);
    // enable and mask opcodes, then accept at instruction end and while halted
    reg_write(`REG_CTRL, 16'h0001);
    reg_read(`REG_STATUS, 16'h0002);
    check("enable", o_irq_enable, 1'b1);
    reg_write(`REG_CTRL, 16'h0002);
    @(negedge i_clk); // flag moves on the strobe's own edge, look once settled
    check("enable", o_irq_enable, 1'b0);
    for (k = 2; k < 4; k++)
    begin
      reg_write(`REG_CTRL, 16'h0001);
      pins(1'b0, 1'b0, 1'b1);
      repeat (6) @(posedge i_clk);
      reg_write(`REG_CTRL, 16'(1 << k));
      wait_lvl(o_irq_accept, 1'b1, 10);
      @(negedge i_clk);
      check("enable", o_irq_enable, 1'b0);
      pins(1'b0, 1'b0, 1'b0);
    end
    // hold floats buses and blocks acceptance
    reg_write(`REG_CTRL, 16'h0001);
    pins(1'b0, 1'b1, 1'b1);
    wait_lvl(o_hold_acknowledge, 1'b1, 10);
    check("addr oe", o_addr_oe, 1'b0);
    check("data oe", o_data_oe, 1'b0);
    reg_read(`REG_STATUS, 16'h0016);
    k = n_acc;
    reg_write(`REG_CTRL, 16'h0004);
    repeat (8) @(posedge i_clk);
    check("accepts", 16'(n_acc - k), 16'h0000);
    pins(1'b0, 1'b0, 1'b1);
    wait_lvl(o_hold_acknowledge, 1'b0, 10);
    reg_write(`REG_CTRL, 16'h0004);
    wait_lvl(o_irq_accept, 1'b1, 10);
    pins(1'b0, 1'b0, 1'b0);
    // sticky taken flag stays until its clear command
    reg_read(`REG_STATUS, 16'h0010);
    reg_write(`REG_CTRL, 16'h0010);
    reg_read(`REG_STATUS, 16'h0000);
    // reset pin held five cycles clears flag and counter
    reg_write(`REG_CTRL, 16'h0001);
    pins(1'b1, 1'b0, 1'b0);
    repeat (4) @(posedge i_clk);
    pins(1'b0, 1'b0, 1'b0);
    repeat (8) @(posedge i_clk);
    check("enable", o_irq_enable, 1'b0);
    reg_read(`REG_PC, 16'h0000);
    repeat (4) @(posedge i_clk);
    final_report();
  end

  initial
  begin
    #2000000;
    n_errors++;
    final_report();
  end
endmodule // testbench
